// ### pkg/snr_pkg.sv
// Constants and types shared by the static network special register access block
package snr_pkg;

  // ------------------------------------------------------------------
  // Widths and sizes
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned ROUTE_W = 15;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned FIFO_CNT_W = 4;
  localparam int unsigned NUM_FIFO = 6;
  localparam int unsigned NUM_IN_FIFO = 5;
  localparam int unsigned NUM_CREDIT = 4;

  // ------------------------------------------------------------------
  // Register word addresses
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 15'h0805;
  localparam logic [ADDR_W-1:0] ADDR_FIFO_WINDOW = 15'h0806;
  localparam logic [ADDR_W-1:0] ADDR_FIFO_SELECTOR = 15'h0807;
  localparam logic [ADDR_W-1:0] ADDR_INPUT_STATE = 15'h0809;
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_STATE = 15'h080A;
  localparam logic [ADDR_W-1:0] ADDR_ROUTE = 15'h080C;
  localparam logic [ADDR_W-1:0] ADDR_DATA_READY = 15'h0900;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int unsigned CTL_FREEZE_FABRIC_BIT = 0;
  localparam int unsigned CTL_FREEZE_PROC_BIT = 1;
  localparam int unsigned DATA_READY_BIT = 0;
  localparam logic RST_FREEZE_FABRIC = 1'b1;
  localparam logic RST_FREEZE_PROC = 1'b1;
  localparam logic [SEL_W-1:0] RST_SELECTOR = 3'h0;
  localparam logic [ROUTE_W-1:0] RST_ROUTE = 15'h0000;
  localparam logic [11:0] STATE_PAD = 12'h000;

  // ------------------------------------------------------------------
  // FIFO selector codes
  // ------------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_NORTH_IN = 3'h0;
  localparam logic [SEL_W-1:0] SEL_EAST_IN = 3'h1;
  localparam logic [SEL_W-1:0] SEL_SOUTH_IN = 3'h2;
  localparam logic [SEL_W-1:0] SEL_WEST_IN = 3'h3;
  localparam logic [SEL_W-1:0] SEL_PROC_IN = 3'h4;
  localparam logic [SEL_W-1:0] SEL_PROC_OUT = 3'h5;

  // ------------------------------------------------------------------
  // Access sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } snr_state_t;

endpackage : snr_pkg

// ### pkg/snr_fifo_if.sv
// Carrier between the access block and one of its network FIFOs
`timescale 1ns/10ps
interface snr_fifo_if #(
  parameter int unsigned W = 32,
  parameter int unsigned CW = 4
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic [W-1:0] next_head;

  modport store (
    input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data, count, next_count, next_head
  );
  modport user (
    output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data, count, next_count, next_head
  );
endinterface : snr_fifo_if

// ### src/snr_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and look-ahead head
`timescale 1ns/10ps
module snr_fifo #(
  parameter int unsigned W = 32,
  parameter int unsigned D = 8,
  parameter int unsigned CW = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Both sides
  snr_fifo_if.store port
);
  localparam int unsigned AW = $clog2(D);
  localparam logic [AW-1:0] LAST = AW'(D - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(D);

  logic [W-1:0] mem [D];
  logic [W-1:0] next_mem [D];
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW-1:0] next_wr_ptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == LAST) ? '0 : AW'(p + 1'b1);
  endfunction : bump

  // Honest flags: full refuses pushes, empty refuses pops
  assign port.in_ready = (count != FULL_CNT);
  assign port.out_valid = (count != '0);
  assign port.out_data = mem[rd_ptr];
  assign port.count = count;
  assign push = port.in_valid & port.in_ready;
  assign pop = port.out_ready & port.out_valid;

  always_comb begin
    next_mem = mem;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    port.next_count = count;
    if (push) begin
      next_mem[wr_ptr] = port.in_data;
      next_wr_ptr = bump(wr_ptr);
    end
    if (pop) begin
      next_rd_ptr = bump(rd_ptr);
    end
    if (push && !pop) begin
      port.next_count = CW'(count + 1'b1);
    end else if (pop && !push) begin
      port.next_count = CW'(count - 1'b1);
    end
    port.next_head = next_mem[next_rd_ptr];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
      for (int i = 0; i < D; i++) begin
        mem[i] <= '0;
      end
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= port.next_count;
      mem <= next_mem;
    end
  end

endmodule : snr_fifo

// ### src/snr_spr_access.sv
// Static network special register access: control, FIFO window, selector and state
`timescale 1ns/10ps
module snr_spr_access (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Special register port from the core
  input wire logic spr_req_i,
  input wire logic spr_write_i,
  input wire logic [snr_pkg::ADDR_W-1:0] spr_addr_i,
  input wire logic [snr_pkg::DATA_W-1:0] spr_wdata_i,
  output logic spr_ack_o,
  output logic [snr_pkg::DATA_W-1:0] spr_rdata_o,
  // Network into the input FIFOs (N, E, S, W, processor input)
  input wire logic [snr_pkg::NUM_IN_FIFO-1:0] net_in_valid_i,
  input wire logic [snr_pkg::NUM_IN_FIFO-1:0][snr_pkg::DATA_W-1:0] net_in_data_i,
  output logic [snr_pkg::NUM_IN_FIFO-1:0] net_in_ready_o,
  // Network out of the processor output FIFO
  output logic net_out_valid_o,
  output logic [snr_pkg::DATA_W-1:0] net_out_data_o,
  input wire logic net_out_ready_i,
  // Output credits of the compass ports (N, E, S, W)
  input wire logic [snr_pkg::NUM_CREDIT-1:0][snr_pkg::FIFO_CNT_W-1:0] net_credit_i,
  // Switch control
  output logic freeze_switch_fabric_o,
  output logic freeze_switch_processor_o,
  output logic [snr_pkg::ROUTE_W-1:0] static_route_o,
  output logic data_ready_flag_o
);

  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  snr_pkg::snr_state_t state;
  snr_pkg::snr_state_t next_state;
  logic [snr_pkg::SEL_W-1:0] selector;
  logic [snr_pkg::SEL_W-1:0] next_selector;
  logic [snr_pkg::ROUTE_W-1:0] next_route;
  logic next_freeze_fabric;
  logic next_freeze_proc;
  logic next_ack;
  logic [snr_pkg::DATA_W-1:0] next_rdata;
  logic [snr_pkg::DATA_W-1:0] rd_word;
  logic next_data_ready;
  logic [snr_pkg::NUM_IN_FIFO-1:0] next_in_ready;
  logic next_out_valid;
  logic [snr_pkg::DATA_W-1:0] next_out_data;

  logic hit_ctl;
  logic hit_win;
  logic hit_sel;
  logic hit_ist;
  logic hit_ost;
  logic hit_route;
  logic hit_ready;
  logic sel_legal;
  logic win_ready;
  logic spr_go;
  logic spr_open;

  logic [snr_pkg::NUM_FIFO-1:0] net_xfer;
  logic [snr_pkg::NUM_FIFO-1:0] hold;
  logic [snr_pkg::NUM_FIFO-1:0] f_in_ready;
  logic [snr_pkg::NUM_FIFO-1:0] f_out_valid;
  logic [snr_pkg::NUM_FIFO-1:0][snr_pkg::DATA_W-1:0] f_head;
  logic [snr_pkg::NUM_FIFO-1:0][snr_pkg::DATA_W-1:0] f_next_head;
  logic [snr_pkg::NUM_FIFO-1:0][snr_pkg::FIFO_CNT_W-1:0] f_cnt;
  logic [snr_pkg::NUM_FIFO-1:0][snr_pkg::FIFO_CNT_W-1:0] f_next_cnt;

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  // Whole-word decode of the full address; holes match nothing
  assign hit_ctl = (spr_addr_i == snr_pkg::ADDR_CONTROL);
  assign hit_win = (spr_addr_i == snr_pkg::ADDR_FIFO_WINDOW);
  assign hit_sel = (spr_addr_i == snr_pkg::ADDR_FIFO_SELECTOR);
  assign hit_ist = (spr_addr_i == snr_pkg::ADDR_INPUT_STATE);
  assign hit_ost = (spr_addr_i == snr_pkg::ADDR_OUTPUT_STATE);
  assign hit_route = (spr_addr_i == snr_pkg::ADDR_ROUTE);
  assign hit_ready = (spr_addr_i == snr_pkg::ADDR_DATA_READY);

  // Codes 6 and 7 select nothing; the window then acts as a hole
  assign sel_legal = (selector <= snr_pkg::SEL_PROC_OUT);
  assign spr_open = (state != snr_pkg::ST_DONE);

  // ------------------------------------------------------------------
  // Network FIFOs, one per selector code
  // ------------------------------------------------------------------
  for (genvar k = 0; k < snr_pkg::NUM_FIFO; k++) begin : g_fifo
    snr_fifo_if #(.W(snr_pkg::DATA_W), .CW(snr_pkg::FIFO_CNT_W)) fif ();
    logic win_hit;

    snr_fifo #(
      .W(snr_pkg::DATA_W),
      .D(snr_pkg::FIFO_DEPTH),
      .CW(snr_pkg::FIFO_CNT_W)
    ) u_fifo (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .port(fif)
    );

    // Window access aimed at this FIFO in the cycle it is carried out
    assign win_hit = spr_go & hit_win & (selector == snr_pkg::SEL_W'(k));
    // Pending window access parks the network side of the same FIFO once it can finish;
    // a stalled access must leave the network free to fill or drain it, or it never ends
    assign hold[k] = spr_req_i & spr_open & hit_win & (selector == snr_pkg::SEL_W'(k)) &
                     (spr_write_i ? f_in_ready[k] : f_out_valid[k]);

    if (k < snr_pkg::NUM_IN_FIFO) begin : g_in
      assign net_xfer[k] = net_in_valid_i[k] & net_in_ready_o[k];
      // Window write and network push never share a cycle
      assign fif.in_valid = (win_hit & spr_write_i) | net_xfer[k];
      assign fif.in_data = win_hit ? spr_wdata_i : net_in_data_i[k];
      // Window read pops the head it returns
      assign fif.out_ready = win_hit & ~spr_write_i;
      assign next_in_ready[k] = ~next_freeze_fabric & ~hold[k] &
                                (f_next_cnt[k] != snr_pkg::FIFO_CNT_W'(snr_pkg::FIFO_DEPTH));
    end else begin : g_out
      assign net_xfer[k] = net_out_valid_o & net_out_ready_i;
      assign fif.in_valid = win_hit & spr_write_i;
      assign fif.in_data = spr_wdata_i;
      assign fif.out_ready = (win_hit & ~spr_write_i) | net_xfer[k];
    end

    assign f_in_ready[k] = fif.in_ready;
    assign f_out_valid[k] = fif.out_valid;
    assign f_head[k] = fif.out_data;
    assign f_next_head[k] = fif.next_head;
    assign f_cnt[k] = fif.count;
    assign f_next_cnt[k] = fif.next_count;
  end

  // Output side: the fabric sees the head only while unfrozen and unparked
  assign next_out_valid = ~next_freeze_fabric & ~hold[snr_pkg::SEL_PROC_OUT] &
                          (f_next_cnt[snr_pkg::SEL_PROC_OUT] != '0);
  assign next_out_data = f_next_head[snr_pkg::SEL_PROC_OUT];

  // Processor input FIFO holding data is what the core can consume
  assign next_data_ready = (f_next_cnt[snr_pkg::SEL_PROC_IN] != '0);

  // ------------------------------------------------------------------
  // Window readiness
  // ------------------------------------------------------------------
  // A network transfer on the chosen FIFO this cycle defers the access one cycle;
  // a write waits for room and a read waits for data, like a blocking port.
  always_comb begin
    win_ready = 1'b1;
    if (sel_legal) begin
      if (net_xfer[selector]) begin
        win_ready = 1'b0;
      end else if (spr_write_i) begin
        win_ready = f_in_ready[selector];
      end else begin
        win_ready = f_out_valid[selector];
      end
    end
  end

  // ------------------------------------------------------------------
  // Read data mux
  // ------------------------------------------------------------------
  always_comb begin
    rd_word = '0; // Holes and undefined codes read zero
    if (hit_ctl) begin
      rd_word[snr_pkg::CTL_FREEZE_FABRIC_BIT] = freeze_switch_fabric_o;
      rd_word[snr_pkg::CTL_FREEZE_PROC_BIT] = freeze_switch_processor_o;
    end else if (hit_win) begin
      if (sel_legal) begin
        rd_word = f_head[selector];
      end
    end else if (hit_sel) begin
      rd_word[snr_pkg::SEL_W-1:0] = selector;
    end else if (hit_ist) begin
      // Processor input count sits in the top field
      rd_word = {snr_pkg::STATE_PAD,
                 f_cnt[snr_pkg::SEL_PROC_IN], f_cnt[snr_pkg::SEL_WEST_IN],
                 f_cnt[snr_pkg::SEL_SOUTH_IN], f_cnt[snr_pkg::SEL_EAST_IN],
                 f_cnt[snr_pkg::SEL_NORTH_IN]};
    end else if (hit_ost) begin
      // Processor output entries above W, S, E, N credits
      rd_word = {snr_pkg::STATE_PAD, f_cnt[snr_pkg::SEL_PROC_OUT],
                 net_credit_i[3], net_credit_i[2], net_credit_i[1], net_credit_i[0]};
    end else if (hit_route) begin
      rd_word[snr_pkg::ROUTE_W-1:0] = static_route_o;
    end else if (hit_ready) begin
      rd_word[snr_pkg::DATA_READY_BIT] = data_ready_flag_o;
    end
  end

  // ------------------------------------------------------------------
  // Access sequencer and register updates
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    spr_go = 1'b0;
    next_selector = selector;
    next_route = static_route_o;
    next_freeze_fabric = freeze_switch_fabric_o;
    next_freeze_proc = freeze_switch_processor_o;
    next_rdata = spr_rdata_o;
    unique case (state)
      snr_pkg::ST_IDLE, snr_pkg::ST_WAIT: begin
        if (spr_req_i) begin
          // Only move-to and move-from exist; both finish with one ack
          if (!hit_win || !sel_legal || win_ready) begin
            spr_go = 1'b1;
            next_state = snr_pkg::ST_DONE;
          end else begin
            next_state = snr_pkg::ST_WAIT;
          end
        end else begin
          next_state = snr_pkg::ST_IDLE;
        end
      end
      snr_pkg::ST_DONE: begin
        // One dead cycle lets the core drop its request after the ack
        next_state = snr_pkg::ST_IDLE;
      end
    endcase
    if (spr_go && !spr_write_i) begin
      next_rdata = rd_word;
    end
    if (spr_go && spr_write_i) begin
      if (hit_ctl) begin
        next_freeze_fabric = spr_wdata_i[snr_pkg::CTL_FREEZE_FABRIC_BIT];
        next_freeze_proc = spr_wdata_i[snr_pkg::CTL_FREEZE_PROC_BIT];
      end
      if (hit_sel) begin
        next_selector = spr_wdata_i[snr_pkg::SEL_W-1:0];
      end
      if (hit_route) begin
        next_route = spr_wdata_i[snr_pkg::ROUTE_W-1:0];
      end
    end
    next_ack = (next_state == snr_pkg::ST_DONE);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= snr_pkg::ST_IDLE;
      selector <= snr_pkg::RST_SELECTOR;
      static_route_o <= snr_pkg::RST_ROUTE;
      freeze_switch_fabric_o <= snr_pkg::RST_FREEZE_FABRIC;
      freeze_switch_processor_o <= snr_pkg::RST_FREEZE_PROC;
      spr_ack_o <= 1'b0;
      spr_rdata_o <= '0;
      data_ready_flag_o <= 1'b0;
      net_in_ready_o <= '0;
      net_out_valid_o <= 1'b0;
      net_out_data_o <= '0;
    end else begin
      state <= next_state;
      selector <= next_selector;
      static_route_o <= next_route;
      freeze_switch_fabric_o <= next_freeze_fabric;
      freeze_switch_processor_o <= next_freeze_proc;
      spr_ack_o <= next_ack;
      spr_rdata_o <= next_rdata;
      data_ready_flag_o <= next_data_ready;
      net_in_ready_o <= next_in_ready;
      net_out_valid_o <= next_out_valid;
      net_out_data_o <= next_out_data;
    end
  end

endmodule : snr_spr_access

// ### sim/snr_access_properties.sv
// Checker for the register port and switch control outputs
`timescale 1ns/10ps
module snr_access_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic spr_req_i,
  input wire logic spr_write_i,
  input wire logic [snr_pkg::ADDR_W-1:0] spr_addr_i,
  input wire logic [snr_pkg::DATA_W-1:0] spr_wdata_i,
  input wire logic spr_ack_o,
  input wire logic [snr_pkg::DATA_W-1:0] spr_rdata_o,
  // Network and switch
  input wire logic [snr_pkg::NUM_IN_FIFO-1:0] net_in_ready_o,
  input wire logic net_out_valid_o,
  input wire logic freeze_switch_fabric_o,
  input wire logic freeze_switch_processor_o,
  input wire logic [snr_pkg::ROUTE_W-1:0] static_route_o,
  input wire logic data_ready_flag_o
);
  logic take;
  logic listed;
  // Ack cycle is the dead cycle, so a request seen there is not new
  assign take = spr_req_i && !spr_ack_o;
  assign listed = spr_addr_i inside {snr_pkg::ADDR_CONTROL, snr_pkg::ADDR_FIFO_WINDOW,
    snr_pkg::ADDR_FIFO_SELECTOR, snr_pkg::ADDR_INPUT_STATE, snr_pkg::ADDR_OUTPUT_STATE,
    snr_pkg::ADDR_ROUTE, snr_pkg::ADDR_DATA_READY};

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_ack_pulse;
    spr_ack_o |=> !spr_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_cause;
    $rose(spr_ack_o) |-> $past(spr_req_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_ctl_read;
    take && !spr_write_i && spr_addr_i == snr_pkg::ADDR_CONTROL |=> spr_ack_o &&
      spr_rdata_o == {30'h0, freeze_switch_processor_o, freeze_switch_fabric_o};
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("control read mismatch");
  property p_hole_read;
    take && !spr_write_i && !listed |=> spr_ack_o && spr_rdata_o == '0;
  endproperty
  a_hole_read: assert property (p_hole_read)
    else $error("unmapped read not zero");
  property p_ctl_write;
    take && spr_write_i && spr_addr_i == snr_pkg::ADDR_CONTROL |=> ##1
      freeze_switch_fabric_o == $past(spr_wdata_i[0], 2) &&
      freeze_switch_processor_o == $past(spr_wdata_i[1], 2);
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("freeze outputs not written");
  property p_route_write;
    take && spr_write_i && spr_addr_i == snr_pkg::ADDR_ROUTE |=> ##1
      static_route_o == $past(spr_wdata_i[14:0], 2);
  endproperty
  a_route_write: assert property (p_route_write)
    else $error("route output not written");
  property p_reset_vals;
    $rose(rst_n_i) |-> freeze_switch_fabric_o && freeze_switch_processor_o &&
      !data_ready_flag_o;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("wrong values out of reset");
  property p_frozen;
    freeze_switch_fabric_o && $past(freeze_switch_fabric_o) |->
      net_in_ready_o == '0 && !net_out_valid_o;
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("network moves while frozen");

  c_write: cover property (take && spr_write_i ##1 spr_ack_o);
  c_ready: cover property (data_ready_flag_o);
  c_out: cover property (net_out_valid_o && !freeze_switch_fabric_o);
endmodule : snr_access_properties

bind snr_spr_access snr_access_properties u_props (.clk_i, .rst_n_i, .spr_req_i,
  .spr_write_i, .spr_addr_i, .spr_wdata_i, .spr_ack_o, .spr_rdata_o, .net_in_ready_o,
  .net_out_valid_o, .freeze_switch_fabric_o, .freeze_switch_processor_o, .static_route_o,
  .data_ready_flag_o);

// ### sim/snr_core_model.sv
// Core model issuing move-to and move-from register accesses
`timescale 1ns/10ps
module snr_core_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [snr_pkg::DATA_W-1:0] rdata_i,
  output logic req_o,
  output logic write_o,
  output logic [snr_pkg::ADDR_W-1:0] addr_o,
  output logic [snr_pkg::DATA_W-1:0] wdata_o
);
  int stalls = 0;

  initial begin
    req_o = 1'b0;
    write_o = 1'b0;
    addr_o = '0;
    wdata_o = '0;
  end

  // Entered at a falling edge; holds all through the ack edge
  task automatic access(input logic wr, input logic [snr_pkg::ADDR_W-1:0] a,
      input logic [snr_pkg::DATA_W-1:0] d, output logic [snr_pkg::DATA_W-1:0] q);
    int n;
    n = 0;
    req_o = 1'b1;
    write_o = wr;
    addr_o = a;
    wdata_o = d;
    do begin
      @(negedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 200);
    // A missing ack is counted so that a hung access cannot pass
    if (ack_i !== 1'b1) begin
      stalls++;
    end
    q = rdata_i;
    @(negedge clk_i);
    // Released lines show the inverse so stale values cannot pass
    req_o = 1'b0;
    write_o = ~wr;
    addr_o = ~a;
    wdata_o = ~d;
    @(negedge clk_i);
  endtask : access
endmodule : snr_core_model

// ### sim/snr_spr_access_test.sv
// Self-checking testbench of the static network register access block
`timescale 1ns/10ps
module snr_spr_access_test;
  localparam logic [14:0] CTL = snr_pkg::ADDR_CONTROL;
  localparam logic [14:0] WIN = snr_pkg::ADDR_FIFO_WINDOW;
  localparam logic [14:0] SEL = snr_pkg::ADDR_FIFO_SELECTOR;
  localparam logic [14:0] IST = snr_pkg::ADDR_INPUT_STATE;
  localparam logic [14:0] OST = snr_pkg::ADDR_OUTPUT_STATE;
  localparam logic [14:0] RTE = snr_pkg::ADDR_ROUTE;
  localparam logic [14:0] RDY = snr_pkg::ADDR_DATA_READY;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req, wr_en, ack, frz_f, frz_p, dready, out_valid;
  logic out_ready = 1'b0;
  logic [14:0] addr;
  logic [31:0] wdata, rdata, out_data;
  logic [4:0] in_valid = '0;
  logic [4:0] in_ready;
  logic [4:0][31:0] in_data = '0;
  logic [3:0][3:0] credit = {4'h4, 4'h3, 4'h2, 4'h1};
  logic [14:0] route;
  int failures = 0;
  int samples_checked = 0;
  int n, t;
  logic go;

  always #25 clk_i = ~clk_i;

  snr_spr_access uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .spr_req_i(req),
    .spr_write_i(wr_en), .spr_addr_i(addr), .spr_wdata_i(wdata), .spr_ack_o(ack),
    .spr_rdata_o(rdata), .net_in_valid_i(in_valid), .net_in_data_i(in_data),
    .net_in_ready_o(in_ready), .net_out_valid_o(out_valid), .net_out_data_o(out_data),
    .net_out_ready_i(out_ready), .net_credit_i(credit), .freeze_switch_fabric_o(frz_f),
    .freeze_switch_processor_o(frz_p), .static_route_o(route), .data_ready_flag_o(dready));
  snr_core_model core (.clk_i(clk_i), .ack_i(ack), .rdata_i(rdata), .req_o(req),
    .write_o(wr_en), .addr_o(addr), .wdata_o(wdata));

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  task automatic rd(input logic [14:0] a, input logic [31:0] e);
    logic [31:0] q;
    core.access(1'b0, a, 32'h0, q);
    chk_word(q, e);
  endtask : rd

  task automatic wr(input logic [14:0] a, input logic [31:0] d);
    logic [31:0] q;
    core.access(1'b1, a, d, q);
  endtask : wr

  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    final_report();
  end

  initial begin
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    rd(CTL, 32'h3);
    rd(SEL, 32'h0);
    rd(RDY, 32'h0);
    rd(IST, 32'h0);
    rd(OST, 32'h4321);
    chk_word({26'h0, out_valid, in_ready}, 32'h0);
    $display("test reset_values done");
    wr(SEL, 32'hFFFFFFFD);
    rd(SEL, 32'h5);
    wr(RTE, 32'hFFFFFFFF);
    rd(RTE, 32'h7FFF);
    chk_word({17'h0, route}, 32'h7FFF);
    foreach (credit[i]) begin
      wr(15'h0808 + 15'(i * 3), 32'hFFFFFFFF);
      rd(15'h0808 + 15'(i * 3), 32'h0);
    end
    wr(15'h7FFF, 32'hFFFFFFFF);
    rd(15'h7FFF, 32'h0);
    wr(CTL, 32'hFFFFFFFE);
    rd(CTL, 32'h2);
    wr(CTL, 32'h0);
    chk_bit(frz_f | frz_p, 1'b0);
    $display("test registers done");
    wr(SEL, 32'h4);
    wr(WIN, 32'hA1);
    wr(WIN, 32'hA2);
    rd(IST, 32'h20000);
    rd(RDY, 32'h1);
    chk_bit(dready, 1'b1);
    rd(WIN, 32'hA1);
    rd(WIN, 32'hA2);
    rd(RDY, 32'h0);
    $display("test window done");
    wr(SEL, 32'h1);
    for (int i = 0; i < 8; i++) wr(WIN, 32'hE0 + i);
    rd(IST, 32'h80);
    chk_bit(in_ready[1], 1'b0);
    for (int i = 0; i < 8; i++) rd(WIN, 32'hE0 + i);
    rd(IST, 32'h0);
    chk_bit(in_ready[1], 1'b1);
    $display("test fill done");
    n = 0;
    t = 0;
    in_valid[0] = 1'b1;
    while (n < 3 && t < 40) begin
      in_data[0] = 32'hC0 + n;
      go = in_ready[0];
      @(negedge clk_i);
      n += int'(go);
      t++;
    end
    in_valid[0] = 1'b0;
    in_data[0] = 32'hFFFFFFFF;
    rd(IST, 32'h3);
    wr(SEL, 32'h0);
    for (int i = 0; i < 3; i++) rd(WIN, 32'hC0 + i);
    // Read of the empty FIFO waits until the network delivers a word
    fork
      rd(WIN, 32'hD0);
      begin
        repeat (6) @(negedge clk_i);
        in_data[0] = 32'hD0;
        in_valid[0] = 1'b1;
        @(negedge clk_i);
        in_valid[0] = 1'b0;
        in_data[0] = 32'hFFFFFFFF;
      end
    join
    rd(IST, 32'h0);
    $display("test network_in done");
    wr(SEL, 32'h5);
    wr(WIN, 32'h5A5A0001);
    wr(WIN, 32'h5A5A0002);
    rd(OST, 32'h24321);
    chk_word(out_data, 32'h5A5A0001);
    chk_bit(out_valid, 1'b1);
    out_ready = 1'b1;
    @(negedge clk_i);
    out_ready = 1'b0;
    repeat (2) @(negedge clk_i);
    chk_word(out_data, 32'h5A5A0002);
    rd(OST, 32'h14321);
    rd(WIN, 32'h5A5A0002);
    $display("test network_out done");
    for (int s = 6; s < 8; s++) begin
      wr(SEL, 32'(s));
      wr(WIN, 32'hFF);
      rd(WIN, 32'h0);
    end
    rd(IST, 32'h0);
    rd(OST, 32'h4321);
    $display("test undefined_select done");
    chk_word(32'(core.stalls), 32'h0);
    final_report();
  end
endmodule : snr_spr_access_test
